// [verilog/tcpwm_chan.sv]
package tcpwm_pkg;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CLK = 8'h04;
  localparam logic [7:0] OFS_PHASE = 8'h08;
  localparam logic [7:0] OFS_DUTY0 = 8'h0c;
  localparam logic [7:0] OFS_DUTY1 = 8'h10;
  localparam logic [7:0] OFS_DUTY2 = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam int unsigned CTRL_EN_LSB = 0;
  localparam int unsigned CTRL_SEL_LSB = 4;
  localparam int unsigned CLK_SRC_BIT = 0;
  localparam int unsigned CLK_PRE_LSB = 1;
  localparam int unsigned PHASE_EN_BIT = 7;
  localparam int unsigned STATUS_REL_LSB = 24;
  localparam logic [2:0] EN_RESET = 3'h0;
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic SRC_RESET = 1'b0;
  localparam logic [1:0] PRE_RESET = 2'h0;
  localparam logic PHASE_AUTO_ENABLE_RESET = 1'b0;
  localparam logic [6:0] PHD_RESET = 7'h00;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

`timescale 1ns/1ps
`default_nettype none

module tcpwm_chan #(
  parameter int unsigned W = tcpwm_pkg::DATA_W
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic tick,
  input wire logic enable,
  input wire logic run,
  input wire logic [W-1:0] duty,
  output logic [W-1:0] count,
  output logic pwm_out
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic [W-1:0] dbuf;
    logic out;
  } tcpwm_chan_type;

  tcpwm_chan_type state_reg;
  tcpwm_chan_type state_next;
  logic wrap;

  assign wrap = enable && run && tick && (state_reg.cnt == {W{1'b1}});

  always_comb begin
    state_next = state_reg;
    if (!enable) begin
      state_next.cnt = '0;
      state_next.dbuf = duty;
    end else if (run && tick) begin
      state_next.cnt = state_reg.cnt + 1'b1;
      if (wrap) begin
        state_next.dbuf = duty;
      end
    end
    // High for duty counts of each 256, so 0 never rises
    state_next.out = enable && (state_next.cnt < state_next.dbuf);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign count = state_reg.cnt;
  assign pwm_out = state_reg.out;

  property p_chan_off;
    @(posedge mclk) disable iff (srst)
      !enable |=> (state_reg.cnt == '0) && !state_reg.out;
  endproperty
  a_chan_off: assert property (p_chan_off) else $error("Disabled channel not cleared");

  property p_duty_zero;
    @(posedge mclk) disable iff (srst)
      (state_reg.dbuf == '0) |-> !state_reg.out;
  endproperty
  a_duty_zero: assert property (p_duty_zero) else $error("Zero duty gave a high output");

  property p_wrap;
    @(posedge mclk) disable iff (srst)
      wrap |=> (state_reg.cnt == '0) && (state_reg.dbuf == $past(duty));
  endproperty
  a_wrap: assert property (p_wrap) else $error("Counter wrap or buffer load wrong");

  property p_buf_hold;
    @(posedge mclk) disable iff (srst)
      (enable && !wrap) |=> state_reg.dbuf == $past(state_reg.dbuf);
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("Duty buffer changed mid period");
endmodule

`default_nettype wire

// [verilog/tcpwm_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tcpwm_top (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic vco_derived_clock,
  input wire logic [2:0] gpio_out,
  input wire logic [2:0] gpio_oe,
  input wire logic cd_enable,
  input wire logic current_detect_output,
  output logic [2:0] port_c_line_out,
  output logic [2:0] port_c_line_oe
);
  typedef struct packed {
    logic [2:0] counter_run_enable;
    logic [2:0] pin_output_select;
    logic counter_source_select;
    logic [1:0] counter_prescale_field;
    logic phase_auto_enable;
    logic [6:0] phase_delay_value;
    logic [2:0][7:0] duty_value_register;
    logic ack;
    logic [31:0] rdata;
    logic vco_s1;
    logic vco_s2;
    logic vco_s3;
    logic cd_s1;
    logic cd_s2;
    logic [2:0] div;
    logic rel1;
    logic rel0;
    logic [2:0] pin;
    logic [2:0] oe;
  } tcpwm_state_type;

  tcpwm_state_type state_reg;
  tcpwm_state_type state_next;

  logic [2:0][7:0] cnt;
  logic [2:0] chan_out;
  logic [2:0] run;
  logic busy;
  logic src_tick;
  logic tick;
  logic grp21;
  logic grp210;
  logic do_write;

  function automatic logic [2:0] pre_mask(input logic [1:0] pre);
    case (pre)
      2'h0: pre_mask = 3'h0;
      2'h1: pre_mask = 3'h1;
      2'h2: pre_mask = 3'h3;
      2'h3: pre_mask = 3'h7;
      default: pre_mask = 3'h0;
    endcase
  endfunction

  // Registers are shut off from the bus while the core sleeps
  assign busy = wait_mode || stop_mode;
  assign avs_waitrequest = (avs_read || avs_write) && (busy || !state_reg.ack);
  assign avs_readdata = state_reg.rdata;
  assign do_write = avs_write && state_reg.ack && !busy && avs_byteenable[0];

  // PLL clock is sampled, so it must run well below mclk / 2
  assign src_tick = state_reg.counter_source_select ?
                    (state_reg.vco_s2 && !state_reg.vco_s3) : 1'b1;
  assign tick = !stop_mode && src_tick &&
                ((state_reg.div & pre_mask(state_reg.counter_prescale_field)) ==
                 pre_mask(state_reg.counter_prescale_field));

  // Phase start-up only for groups 2-1 and 2-1-0
  assign grp21 = state_reg.phase_auto_enable && state_reg.counter_run_enable[2] &&
                 state_reg.counter_run_enable[1];
  assign grp210 = grp21 && state_reg.counter_run_enable[0];
  assign run[2] = 1'b1;
  assign run[1] = !grp21 || state_reg.rel1;
  assign run[0] = !grp210 || state_reg.rel0;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_chan
      tcpwm_chan #(
        .W(tcpwm_pkg::DATA_W)
      ) u_chan (
        .mclk(mclk),
        .srst(srst),
        .tick(tick),
        .enable(state_reg.counter_run_enable[gi]),
        .run(run[gi]),
        .duty(state_reg.duty_value_register[gi]),
        .count(cnt[gi]),
        .pwm_out(chan_out[gi])
      );
    end
  endgenerate

  always_comb begin
    state_next = state_reg;
    state_next.vco_s1 = vco_derived_clock;
    state_next.vco_s2 = state_reg.vco_s1;
    state_next.vco_s3 = state_reg.vco_s2;
    state_next.cd_s1 = current_detect_output;
    state_next.cd_s2 = state_reg.cd_s1;
    if (!stop_mode && src_tick) begin
      state_next.div = state_reg.div + 3'h1;
    end

    state_next.ack = (avs_read || avs_write) && !busy && !state_reg.ack;
    if (state_next.ack && avs_read) begin
      case (avs_address)
        tcpwm_pkg::OFS_CTRL: state_next.rdata =
          32'({state_reg.pin_output_select, 1'b0, state_reg.counter_run_enable});
        tcpwm_pkg::OFS_CLK: state_next.rdata =
          32'({state_reg.counter_prescale_field, state_reg.counter_source_select});
        tcpwm_pkg::OFS_PHASE: state_next.rdata =
          32'({state_reg.phase_auto_enable, state_reg.phase_delay_value});
        tcpwm_pkg::OFS_DUTY0: state_next.rdata = 32'(state_reg.duty_value_register[0]);
        tcpwm_pkg::OFS_DUTY1: state_next.rdata = 32'(state_reg.duty_value_register[1]);
        tcpwm_pkg::OFS_DUTY2: state_next.rdata = 32'(state_reg.duty_value_register[2]);
        tcpwm_pkg::OFS_STATUS: state_next.rdata =
          32'({state_reg.rel0, state_reg.rel1, cnt[2], cnt[1], cnt[0]});
        default: state_next.rdata = tcpwm_pkg::UNMAPPED_READ;
      endcase
    end

    if (do_write) begin
      case (avs_address)
        tcpwm_pkg::OFS_CTRL: begin
          state_next.counter_run_enable = avs_writedata[tcpwm_pkg::CTRL_EN_LSB +: 3];
          state_next.pin_output_select = avs_writedata[tcpwm_pkg::CTRL_SEL_LSB +: 3];
        end
        tcpwm_pkg::OFS_CLK: begin
          state_next.counter_source_select = avs_writedata[tcpwm_pkg::CLK_SRC_BIT];
          state_next.counter_prescale_field = avs_writedata[tcpwm_pkg::CLK_PRE_LSB +: 2];
        end
        tcpwm_pkg::OFS_PHASE: begin
          state_next.phase_auto_enable = avs_writedata[tcpwm_pkg::PHASE_EN_BIT];
          state_next.phase_delay_value = avs_writedata[6:0];
        end
        tcpwm_pkg::OFS_DUTY0: state_next.duty_value_register[0] = avs_writedata[7:0];
        tcpwm_pkg::OFS_DUTY1: state_next.duty_value_register[1] = avs_writedata[7:0];
        tcpwm_pkg::OFS_DUTY2: state_next.duty_value_register[2] = avs_writedata[7:0];
        default: state_next.rdata = state_reg.rdata;
      endcase
    end

    // Release flags latch, so later delay writes cannot move the phase
    if (!state_reg.counter_run_enable[1]) begin
      state_next.rel1 = 1'b0;
    end else if (grp21 && cnt[2] == {1'b0, state_reg.phase_delay_value}) begin
      state_next.rel1 = 1'b1;
    end
    if (!state_reg.counter_run_enable[0]) begin
      state_next.rel0 = 1'b0;
    end else if (grp210 && state_reg.rel1 &&
                 cnt[1] == {1'b0, state_reg.phase_delay_value}) begin
      state_next.rel0 = 1'b1;
    end

    // Pin 0: current detect wins over the modulator, which wins over GPIO
    for (int i = 0; i < 3; i++) begin
      state_next.pin[i] = state_reg.pin_output_select[i] ? chan_out[i] : gpio_out[i];
      state_next.oe[i] = state_reg.pin_output_select[i] || gpio_oe[i];
    end
    if (cd_enable) begin
      state_next.pin[0] = state_reg.cd_s2;
      state_next.oe[0] = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= '0;
      state_reg.counter_run_enable <= tcpwm_pkg::EN_RESET;
      state_reg.pin_output_select <= tcpwm_pkg::SEL_RESET;
      state_reg.counter_source_select <= tcpwm_pkg::SRC_RESET;
      state_reg.counter_prescale_field <= tcpwm_pkg::PRE_RESET;
      state_reg.phase_auto_enable <= tcpwm_pkg::PHASE_AUTO_ENABLE_RESET;
      state_reg.phase_delay_value <= tcpwm_pkg::PHD_RESET;
      state_reg.duty_value_register <= {3{tcpwm_pkg::DUTY_RESET}};
    end else begin
      state_reg <= state_next;
    end
  end

  assign port_c_line_out = state_reg.pin;
  assign port_c_line_oe = state_reg.oe;

  property p_hold1;
    @(posedge mclk) disable iff (srst)
      (grp21 && !state_reg.rel1) |-> cnt[1] == 8'h00;
  endproperty
  a_hold1: assert property (p_hold1) else $error("Channel 1 ran before release");

  property p_rel1;
    @(posedge mclk) disable iff (srst)
      (grp21 && cnt[2] == {1'b0, state_reg.phase_delay_value}) |=> state_reg.rel1;
  endproperty
  a_rel1: assert property (p_rel1) else $error("Channel 1 not released at delay");

  property p_rel0;
    @(posedge mclk) disable iff (srst)
      (grp210 && state_reg.rel1 && cnt[1] == {1'b0, state_reg.phase_delay_value})
        |=> state_reg.rel0;
  endproperty
  a_rel0: assert property (p_rel0) else $error("Channel 0 not released at delay");

  property p_no_group;
    @(posedge mclk) disable iff (srst)
      (state_reg.counter_run_enable[2:1] != 2'h3) |-> run[1] && run[0];
  endproperty
  a_no_group: assert property (p_no_group) else $error("Phase hold outside a group");

  property p_wait_block;
    @(posedge mclk) disable iff (srst)
      (wait_mode && (avs_read || avs_write)) |-> avs_waitrequest;
  endproperty
  a_wait_block: assert property (p_wait_block) else $error("Bus answered in wait mode");

  property p_stop_hold;
    @(posedge mclk) disable iff (srst)
      (stop_mode && !do_write) |=> (cnt == $past(cnt)) && (chan_out == $past(chan_out));
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("State moved in stop mode");

  sequence s_pwm_pin;
    state_reg.pin_output_select[1] ##1 1'b1;
  endsequence
  property p_pin1;
    @(posedge mclk) disable iff (srst)
      s_pwm_pin |-> port_c_line_out[1] == $past(chan_out[1]) && port_c_line_oe[1];
  endproperty
  a_pin1: assert property (p_pin1) else $error("Pin 1 not driven by channel 1");

  property p_fast_tick;
    @(posedge mclk) disable iff (srst)
      (!state_reg.counter_source_select && state_reg.counter_prescale_field == 2'h0 &&
       !stop_mode) |-> tick;
  endproperty
  a_fast_tick: assert property (p_fast_tick) else $error("Undivided bus clock missed a tick");

  property p_div8;
    @(posedge mclk) disable iff (srst)
      (tick && state_reg.counter_prescale_field == 2'h3 && !state_reg.counter_source_select)
        |=> (!tick || state_reg.counter_prescale_field != 2'h3 ||
             state_reg.counter_source_select) [*7];
  endproperty
  a_div8: assert property (p_div8) else $error("Divide by 8 ticked early");
endmodule

`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_readdata, q, s1, s2;
  logic avs_waitrequest;
  logic wait_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic vco = 1'b0;
  logic cd_enable = 1'b0;
  logic cd_in = 1'b0;
  logic [2:0] gpio_out = 3'h0;
  logic [2:0] gpio_oe = 3'h0;
  logic [2:0] port_c_line_out, port_c_line_oe, pins;
  logic [7:0] duty[3];
  logic [7:0] tbl[3] = '{8'h00, 8'h80, 8'hff};
  int bad_count = 0;
  int n_tests = 0;
  int seed = 22;
  int hi[3];

  always #5 mclk = ~mclk;
  // PLL stand-in at a quarter of mclk, edges on mclk falling edges, off the rising ones
  always #20 vco = ~vco;

  tcpwm_top dut_u (.mclk(mclk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wait_mode(wait_mode),
    .stop_mode(stop_mode), .vco_derived_clock(vco), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .cd_enable(cd_enable), .current_detect_output(cd_in), .port_c_line_out(port_c_line_out),
    .port_c_line_oe(port_c_line_oe));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Holds the request until waitrequest is sampled low; read data taken at that edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20000);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 20000) bad_count++;
  endtask

  task automatic measure(input int len);
    hi = '{0, 0, 0};
    repeat (len) begin
      @(posedge mclk);
      for (int c = 0; c < 3; c++) hi[c] += (port_c_line_out[c] === 1'b1);
    end
  endtask

  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      bus(1'b0, tcpwm_pkg::OFS_STATUS, 32'h0);
      n++;
    end while (q[b] !== 1'b1 && n < 2000);
  endtask

  initial begin
    repeat (60000) @(posedge mclk);
    bad_count++;
    print_verdict();
  end

  initial begin
    int len;
    time t0;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    // Every place reads zero after reset, the unmapped one too
    for (int a = 0; a < 32; a += 4) begin
      bus(1'b0, 8'(a), 32'h0);
      check(q, 32'h0);
    end
    avs_byteenable <= 4'h0;
    bus(1'b1, tcpwm_pkg::OFS_DUTY0, 32'h55);
    avs_byteenable <= 4'h1;
    bus(1'b0, tcpwm_pkg::OFS_DUTY0, 32'h0);
    check(q, 32'h0);
    gpio_out <= 3'($random(seed));
    gpio_oe <= 3'($random(seed));
    repeat (3) @(posedge mclk);
    check({port_c_line_oe, port_c_line_out}, {gpio_oe, gpio_out});
    // Pass 0 fixed duty table at prescale 0, then random duties over prescales 1 to 3 and the PLL source
    for (int p = 0; p < 5; p++) begin
      for (int c = 0; c < 3; c++) begin
        duty[c] = (p == 0) ? tbl[c] : 8'($random(seed));
        bus(1'b1, 8'(tcpwm_pkg::OFS_DUTY0 + 4 * c), {24'h0, duty[c]});
      end
      bus(1'b1, tcpwm_pkg::OFS_CLK, {29'h0, (p == 4) ? 2'h0 : 2'(p), p == 4});
      if (p == 0) bus(1'b1, tcpwm_pkg::OFS_CTRL, 32'h77);
      len = (p == 4) ? 1024 : 256 << p;
      repeat (2 * len) @(posedge mclk);
      measure(len);
      for (int c = 0; c < 3; c++) check(hi[c], duty[c] * len / 256);
      check(port_c_line_oe, 3'h7);
    end
    cd_enable <= 1'b1;
    cd_in <= 1'b1;
    repeat (5) @(posedge mclk);
    check(port_c_line_out[0], 1'b1);
    cd_in <= 1'b0;
    repeat (5) @(posedge mclk);
    check(port_c_line_out[0], 1'b0);
    cd_enable <= 1'b0;
    // Bus stalls in wait mode while the counters keep going
    bus(1'b0, tcpwm_pkg::OFS_STATUS, 32'h0);
    s1 = q;
    t0 = $time;
    wait_mode <= 1'b1;
    fork
      begin
        repeat (200) @(posedge mclk);
        wait_mode <= 1'b0;
      end
      bus(1'b0, tcpwm_pkg::OFS_STATUS, 32'h0);
    join
    check(($time - t0) >= 2000, 1'b1);
    check((8'(q[23:16] - s1[23:16]) >= 8'd45) && (8'(q[23:16] - s1[23:16]) <= 8'd60), 1'b1);
    // Stop mode freezes counters and pins
    bus(1'b0, tcpwm_pkg::OFS_STATUS, 32'h0);
    s1 = q;
    stop_mode <= 1'b1;
    repeat (3) @(posedge mclk);
    pins = port_c_line_out;
    repeat (300) @(posedge mclk);
    check(port_c_line_out, pins);
    stop_mode <= 1'b0;
    bus(1'b0, tcpwm_pkg::OFS_STATUS, 32'h0);
    check(8'(q[23:16] - s1[23:16]) <= 8'd3, 1'b1);
    bus(1'b1, tcpwm_pkg::OFS_CTRL, 32'h70);
    repeat (4) @(posedge mclk);
    check(port_c_line_out, 3'h0);
    bus(1'b0, tcpwm_pkg::OFS_STATUS, 32'h0);
    check(q[23:0], 24'h0);
    // Phase start-up: delay changed between the two releases
    bus(1'b1, tcpwm_pkg::OFS_CTRL, 32'h00);
    bus(1'b1, tcpwm_pkg::OFS_PHASE, 32'ha0);
    bus(1'b1, tcpwm_pkg::OFS_CLK, 32'h6);
    bus(1'b1, tcpwm_pkg::OFS_CTRL, 32'h70);
    bus(1'b1, tcpwm_pkg::OFS_CTRL, 32'h77);
    poll(24);
    check(q[25], 1'b0);
    bus(1'b1, tcpwm_pkg::OFS_PHASE, 32'hc0);
    poll(25);
    bus(1'b0, tcpwm_pkg::OFS_STATUS, 32'h0);
    s1 = q;
    check(8'(s1[23:16] - s1[15:8] - 8'h20) <= 8'd2, 1'b1);
    check(8'(s1[15:8] - s1[7:0] - 8'h40) <= 8'd2, 1'b1);
    bus(1'b1, tcpwm_pkg::OFS_PHASE, 32'h85);
    repeat (3000) @(posedge mclk);
    bus(1'b0, tcpwm_pkg::OFS_STATUS, 32'h0);
    s2 = q;
    check({8'(s2[23:16] - s2[15:8]), 8'(s2[15:8] - s2[7:0])},
      {8'(s1[23:16] - s1[15:8]), 8'(s1[15:8] - s1[7:0])});
    // Channels 2 and 0 alone are not a phase group: both run at once
    bus(1'b1, tcpwm_pkg::OFS_CTRL, 32'h70);
    bus(1'b1, tcpwm_pkg::OFS_CLK, 32'h0);
    bus(1'b1, tcpwm_pkg::OFS_PHASE, 32'hb0);
    bus(1'b1, tcpwm_pkg::OFS_CTRL, 32'h75);
    repeat (20) @(posedge mclk);
    bus(1'b0, tcpwm_pkg::OFS_STATUS, 32'h0);
    check(8'(q[23:16] - q[7:0]) <= 8'd1, 1'b1);
    check(q[15:8], 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
